// ==== inc/sfb_pkg.sv ====
// Constants, command codes and register map of the burst command port.
// Assumes one rising-edge clock shared by the pins and the AHB-Lite bus.
// Contract
// - Write takes bank selects and column A0-A7.
// - Write word stored only when mask low.
// - Write command with mask high is no-op; code still clears a pending command load.
// - Row close: line high all banks, else one.
// - Burst stop truncates latest read or write.
// - Command load passes code to execution logic.
// - Activate after command load opens no row.
// - First read word after CAS latency, then one/edge.
// - Burst end floats outputs; full page wraps.
// - New read chains directly behind last word.
// - Read accepted any cycle after a read.
// - Registered write floats data pins; mask low.
// - Write bursts of 1, 2, 4 or 8.
// - Write data from command edge; excess ignored.
// - Read mask applies two clocks after sampling.
// - Single write mode bit forces one-column writes.
// - Decode high, low, low as write command.
package sfb_pkg;

	// Register byte offsets
	localparam logic [7:0] REG_CFG = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [7:0] REG_CMDX = 8'h08;
	localparam logic [7:0] REG_ROW_BASE = 8'h10;
	localparam logic [7:0] REG_ROW_STEP = 8'h04;

	// Config fields: latency, burst code, single write mode
	localparam int CFG_CL_LSB = 0;
	localparam int CFG_BL_LSB = 2;
	localparam int CFG_SWM_BIT = 5;
	localparam int CFG_W = 6;
	localparam logic [5:0] CFG_RST = 6'h02;

	// Burst code that means full page
	localparam logic [2:0] BL_FULL = 3'h7;
	// Longest fixed burst
	localparam logic [3:0] BL_MAX = 4'h8;

	// Status fields
	localparam int STAT_OPEN_LSB = 0;
	localparam int STAT_PEND_BIT = 4;
	localparam int STAT_RD_BIT = 5;
	localparam int STAT_WR_BIT = 6;

	// Read path source chosen by the execution logic
	localparam logic [1:0] SRC_ARRAY = 2'h0;
	localparam logic [1:0] SRC_IDENT = 2'h1;
	localparam logic [1:0] SRC_STATUS = 2'h2;

	// Pin commands, one-hot
	typedef enum logic [7:0] {
		CMD_NOP = 8'h01,
		CMD_ACT = 8'h02,
		CMD_READ = 8'h04,
		CMD_WRITE = 8'h08,
		CMD_BSTOP = 8'h10,
		CMD_RCLOSE = 8'h20,
		CMD_CLOAD = 8'h40,
		CMD_MODE = 8'h80
	} sfb_cmd_e;

endpackage

// ==== rtl/sfb_cmd_decode.sv ====
// Decodes the four command strobes into a one-hot command.
// Assumes strobes already synchronous to hclk.
`timescale 1ns/1ps
module sfb_cmd_decode
(
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	output sfb_pkg::sfb_cmd_e cmd
);

	// Deselect reads as a plain no-op
	always_comb
	begin
		if (cs_n)
			cmd = sfb_pkg::CMD_NOP;
		else
		begin
			case ({ras_n, cas_n, we_n})
				3'h3: cmd = sfb_pkg::CMD_ACT;
				3'h5: cmd = sfb_pkg::CMD_READ;
				3'h4: cmd = sfb_pkg::CMD_WRITE;
				3'h6: cmd = sfb_pkg::CMD_BSTOP;
				3'h2: cmd = sfb_pkg::CMD_RCLOSE;
				3'h1: cmd = sfb_pkg::CMD_CLOAD;
				3'h0: cmd = sfb_pkg::CMD_MODE;
				default: cmd = sfb_pkg::CMD_NOP;
			endcase
		end
	end

endmodule

// ==== rtl/sfb_store.sv ====
// Flip-flop word store, one write port and one unregistered read port.
// Assumes the caller registers what it reads out.
`timescale 1ns/1ps
module sfb_store
#(
	parameter int DW = 16,
	parameter int AW = 10
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);

	// Whole store as one packed record
	typedef struct packed {
		logic [(1<<AW)-1:0][DW-1:0] mem;
	} sfb_store_s;

	sfb_store_s q;
	sfb_store_s d;

	// Read is combinational from the held words
	assign rdata = q.mem[raddr];

	// Single write per cycle
	always_comb
	begin
		d = q;
		if (we)
			d.mem[waddr] = wdata;
	end

	// Cleared store after reset
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			q <= '0;
		else
			q <= d;
	end

endmodule

// ==== rtl/sfb_port.sv ====
// Burst command port: bank rows, read and write bursts, mask, command loads.
// Assumes pins synchronous to hclk and an AHB-Lite master on the register side.
`timescale 1ns/1ps
module sfb_port
#(
	parameter int DATA_W = 16,
	parameter int COL_W = 8
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [11:0] addr,
	input wire logic bank_select_low,
	input wire logic bank_select_high,
	input wire logic dqm,
	input wire logic [DATA_W-1:0] dq_in,
	output logic [DATA_W-1:0] dq_out,
	output logic dq_oe_n,
	input wire logic [1:0] read_source,
	input wire logic [DATA_W-1:0] ident_word,
	input wire logic [DATA_W-1:0] status_word,
	output logic [7:0] cmd_exec_code,
	output logic cmd_exec_stb
);

	localparam int AW = COL_W + 2;

	// Refuse widths the bus word or burst counters cannot carry
	if (DATA_W < 1 || DATA_W > 32 || COL_W < 3 || COL_W > 8)
	begin : g_bad
		$error("sfb_port: unsupported DATA_W or COL_W");
	end

	// All block state
	typedef struct packed {
		logic [3:0] open;
		logic [3:0][11:0] row;
		logic ld_pend;
		logic last_wr;
		logic rd_act;
		logic rd_full;
		logic [1:0] rd_bank;
		logic [COL_W-1:0] rd_col;
		logic [3:0] rd_left;
		logic wr_act;
		logic [1:0] wr_bank;
		logic [COL_W-1:0] wr_col;
		logic [3:0] wr_left;
		logic [1:0] pv;
		logic [1:0][DATA_W-1:0] pd;
		logic dqm;
		logic [DATA_W-1:0] dq_out;
		logic dq_oe_n;
		logic [7:0] ce_code;
		logic ce_stb;
		logic [sfb_pkg::CFG_W-1:0] cfg;
		logic aw_pend;
		logic [7:0] aw_addr;
		logic [31:0] hrdata;
		logic hrdy;
		logic hresp;
	} sfb_st_s;

	sfb_st_s q;
	sfb_st_s d;

	sfb_pkg::sfb_cmd_e cmd;
	logic [1:0] bank;
	logic all_bank_terminate_line;
	logic iss_v;
	logic [1:0] iss_bank;
	logic [COL_W-1:0] iss_col;
	logic [DATA_W-1:0] arr_word;
	logic [DATA_W-1:0] word;
	logic sel_v;
	logic [DATA_W-1:0] sel_d;
	logic st_we;
	logic [AW-1:0] st_waddr;
	logic wr_flush;
	logic [3:0] rlen;
	logic [3:0] wlen;
	logic acc;
	logic [sfb_pkg::CFG_W-1:0] cfg_now;

	// Burst length from the mode code; full page handled apart
	function automatic logic [3:0] blen(input logic [2:0] code);
		case (code)
			3'h0: blen = 4'h1;
			3'h1: blen = 4'h2;
			3'h2: blen = 4'h4;
			default: blen = sfb_pkg::BL_MAX;
		endcase
	endfunction

	// Register read mux; unmapped offsets read zero
	function automatic logic [31:0] reg_rd(input logic [7:0] a, input sfb_st_s s,
		input logic [sfb_pkg::CFG_W-1:0] c);
		reg_rd = 32'h0000_0000;
		if (a == sfb_pkg::REG_CFG)
			reg_rd[sfb_pkg::CFG_W-1:0] = c;
		else if (a == sfb_pkg::REG_STAT)
		begin
			reg_rd[sfb_pkg::STAT_OPEN_LSB +: 4] = s.open;
			reg_rd[sfb_pkg::STAT_PEND_BIT] = s.ld_pend;
			reg_rd[sfb_pkg::STAT_RD_BIT] = s.rd_act;
			reg_rd[sfb_pkg::STAT_WR_BIT] = s.wr_act;
		end
		else if (a == sfb_pkg::REG_CMDX)
			reg_rd[7:0] = s.ce_code;
		for (int b = 0; b < 4; b++)
		begin
			if (a == sfb_pkg::REG_ROW_BASE + 8'(b) * sfb_pkg::REG_ROW_STEP)
				reg_rd[11:0] = s.row[b];
		end
	endfunction

	// Strobe decode
	sfb_cmd_decode u_dec
	(
		.cs_n(cs_n),
		.ras_n(ras_n),
		.cas_n(cas_n),
		.we_n(we_n),
		.cmd(cmd)
	);

	// Array words; rows are tracked but do not widen the store
	sfb_store #(.DW(DATA_W), .AW(AW)) u_store
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.we(st_we),
		.waddr(st_waddr),
		.wdata(dq_in),
		.raddr({iss_bank, iss_col}),
		.rdata(arr_word)
	);

	// bank from the two select inputs
	assign bank = {bank_select_high, bank_select_low};
	assign all_bank_terminate_line = addr[10];
	assign acc = hsel && htrans[1] && hready;
	// Forward a config write still in its data phase
	assign cfg_now = (q.aw_pend && q.aw_addr == sfb_pkg::REG_CFG) ?
		hwdata[sfb_pkg::CFG_W-1:0] : q.cfg;

	// Next state of the whole port
	always_comb
	begin
		d = q;
		d.dqm = dqm;
		d.ce_stb = 1'b0;
		iss_v = 1'b0;
		iss_bank = q.rd_bank;
		iss_col = q.rd_col;
		st_we = 1'b0;
		st_waddr = {q.wr_bank, q.wr_col};
		wr_flush = 1'b0;
		rlen = blen(q.cfg[sfb_pkg::CFG_BL_LSB +: 3]);
		// single write mode forces one column
		// write bursts of 1, 2, 4 or 8
		wlen = q.cfg[sfb_pkg::CFG_SWM_BIT] ? 4'h1 : rlen;

		// Bus: zero wait states, always OKAY
		d.hrdy = 1'b1;
		// No error response exists, so OKAY is held in a flop
		d.hresp = 1'b0;
		d.aw_pend = acc && hwrite;
		if (acc)
		begin
			d.aw_addr = haddr[7:0];
			if (!hwrite)
				d.hrdata = reg_rd(haddr[7:0], q, cfg_now);
		end
		if (q.aw_pend && q.aw_addr == sfb_pkg::REG_CFG)
			d.cfg = hwdata[sfb_pkg::CFG_W-1:0];

		// burst runs out, full page wraps the column
		if (q.rd_act)
		begin
			iss_v = 1'b1;
			d.rd_col = q.rd_col + 1'b1;
			d.rd_left = q.rd_left - 4'h1;
			d.rd_act = q.rd_full || q.rd_left > 4'h1;
		end

		// later words on each edge, then input ignored
		if (q.wr_act)
		begin
			st_we = !dqm;
			d.wr_col = q.wr_col + 1'b1;
			d.wr_left = q.wr_left - 4'h1;
			d.wr_act = q.wr_left > 4'h1;
		end

		case (cmd)
			sfb_pkg::CMD_ACT:
			begin
				// activate inside a load sequence opens nothing
				if (!q.ld_pend)
				begin
					d.open[bank] = 1'b1;
					d.row[bank] = addr;
				end
			end
			sfb_pkg::CMD_READ:
			begin
				// new read replaces the running burst
				iss_v = 1'b1;
				iss_bank = bank;
				iss_col = addr[COL_W-1:0];
				d.rd_bank = bank;
				d.rd_col = addr[COL_W-1:0] + 1'b1;
				d.rd_left = rlen - 4'h1;
				d.rd_full = q.cfg[sfb_pkg::CFG_BL_LSB +: 3] == sfb_pkg::BL_FULL;
				d.rd_act = d.rd_full || rlen > 4'h1;
				d.last_wr = 1'b0;
				d.ld_pend = 1'b0;
			end
			sfb_pkg::CMD_WRITE:
			begin
				d.ld_pend = 1'b0;
				if (!dqm)
				begin
					st_we = 1'b1;
					st_waddr = {bank, addr[COL_W-1:0]};
					d.wr_bank = bank;
					d.wr_col = addr[COL_W-1:0] + 1'b1;
					d.wr_left = wlen - 4'h1;
					d.wr_act = wlen > 4'h1;
					d.last_wr = 1'b1;
					wr_flush = 1'b1;
					iss_v = 1'b0;
					d.rd_act = 1'b0;
				end
			end
			sfb_pkg::CMD_BSTOP:
			begin
				// stop the latest burst, any bank
				if (q.last_wr)
				begin
					st_we = 1'b0;
					d.wr_act = 1'b0;
				end
				else
				begin
					iss_v = 1'b0;
					d.rd_act = 1'b0;
				end
			end
			sfb_pkg::CMD_RCLOSE:
			begin
				// all banks or the selected one
				if (all_bank_terminate_line)
				begin
					d.open = 4'h0;
					iss_v = 1'b0;
					d.rd_act = 1'b0;
				end
				else
				begin
					d.open[bank] = 1'b0;
					if (q.rd_bank == bank)
					begin
						iss_v = 1'b0;
						d.rd_act = 1'b0;
					end
				end
			end
			sfb_pkg::CMD_CLOAD:
			begin
				// hand the code to the execution logic
				d.ce_stb = 1'b1;
				d.ce_code = addr[7:0];
				d.ld_pend = 1'b1;
			end
			default:
			begin
				// No-op, deselect and mode load leave state alone
			end
		endcase

		// Read path source chosen by the execution logic
		case (read_source)
			sfb_pkg::SRC_IDENT: word = ident_word;
			sfb_pkg::SRC_STATUS: word = status_word;
			default: word = arr_word;
		endcase

		// Latency pipe behind the issue stage
		d.pv = {q.pv[0], iss_v};
		d.pd = {q.pd[0], word};

		case (q.cfg[sfb_pkg::CFG_CL_LSB +: 2])
			2'h1:
			begin
				sel_v = iss_v;
				sel_d = word;
			end
			2'h3:
			begin
				sel_v = q.pv[1];
				sel_d = q.pd[1];
			end
			default:
			begin
				sel_v = q.pv[0];
				sel_d = q.pd[0];
			end
		endcase

		// mask from two edges back floats the word
		d.dq_out = sel_d;
		d.dq_oe_n = !(sel_v && !q.dqm);
		if (wr_flush)
		begin
			d.pv = 2'h0;
			d.dq_oe_n = 1'b1;
		end
	end

	// State register; pins float and bus is ready out of reset
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			q <= '0;
			q.cfg <= sfb_pkg::CFG_RST;
			q.dq_oe_n <= 1'b1;
			q.hrdy <= 1'b1;
		end
		else
			q <= d;
	end

	// Outputs straight from the state register
	assign hreadyout = q.hrdy;
	assign hresp = q.hresp;
	assign hrdata = q.hrdata;
	assign dq_out = q.dq_out;
	assign dq_oe_n = q.dq_oe_n;
	assign cmd_exec_code = q.ce_code;
	assign cmd_exec_stb = q.ce_stb;

	chk_masked_write_nop: assert property (@(posedge hclk) disable iff (!hresetn)
		(cmd == sfb_pkg::CMD_WRITE && dqm && !q.wr_act) |-> !st_we)
		else $error("masked write command stored a word");

	chk_burst_mask_skip: assert property (@(posedge hclk) disable iff (!hresetn)
		(q.wr_act && dqm) |-> !st_we)
		else $error("masked burst word was stored");

	chk_write_floats: assert property (@(posedge hclk) disable iff (!hresetn)
		(cmd == sfb_pkg::CMD_WRITE && !dqm) |=> dq_oe_n && !q.pv[0])
		else $error("data pins driven after write command");

	chk_cl1_first_word: assert property (@(posedge hclk) disable iff (!hresetn)
		(cmd == sfb_pkg::CMD_READ && q.cfg[1:0] == 2'h1 && !q.dqm) |=> !dq_oe_n)
		else $error("first read word late at latency one");

	chk_mask_two_clk: assert property (@(posedge hclk) disable iff (!hresetn)
		dqm |-> ##2 dq_oe_n)
		else $error("read word not floated two clocks after mask");

	chk_load_no_open: assert property (@(posedge hclk) disable iff (!hresetn)
		(cmd == sfb_pkg::CMD_ACT && q.ld_pend) |=> q.open == $past(q.open))
		else $error("activate in load sequence opened a row");

	chk_act_opens: assert property (@(posedge hclk) disable iff (!hresetn)
		(cmd == sfb_pkg::CMD_ACT && !q.ld_pend) |=> q.open[$past(bank)]
		&& q.row[$past(bank)] == $past(addr))
		else $error("activate did not record the row");

	chk_all_bank_stop: assert property (@(posedge hclk) disable iff (!hresetn)
		(cmd == sfb_pkg::CMD_RCLOSE && addr[10]) |=> !q.rd_act && q.open == 4'h0)
		else $error("all-bank row close left a burst running");

	chk_bstop_read: assert property (@(posedge hclk) disable iff (!hresetn)
		(cmd == sfb_pkg::CMD_BSTOP && !q.last_wr) |-> !iss_v ##1 !q.rd_act)
		else $error("burst stop did not end the read");

	chk_load_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
		(cmd == sfb_pkg::CMD_CLOAD) |=> cmd_exec_stb && cmd_exec_code == $past(addr[7:0])
		##1 !cmd_exec_stb || $past(cmd == sfb_pkg::CMD_CLOAD))
		else $error("command load not passed on");

endmodule

// ==== tb/sfb_ctrl_model.sv ====
// Memory controller model that drives the command, mask and write data pins.
// Assumes its tasks are called right after a rising hclk edge.
`timescale 1ns/1ps
module sfb_ctrl_model
#(
	parameter int ACT_GAP = 2,
	parameter logic [7:0] PROG_CODE = 8'h10
)
(
	input wire logic hclk,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [11:0] addr,
	output logic bank_select_low,
	output logic bank_select_high,
	output logic dqm,
	output logic [15:0] dq_d
);
	// Selected and idle from time zero
	initial
	begin
		cs_n = 1'b0;
		{ras_n, cas_n, we_n} = 3'h7;
		addr = 12'h000;
		{bank_select_high, bank_select_low} = 2'h0;
		dqm = 1'b0;
		dq_d = 16'h0000;
	end

	// One command edge: strobes, bank, address, mask and data
	task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a,
		input logic m, input logic [15:0] d);
		{ras_n, cas_n, we_n} <= c;
		{bank_select_high, bank_select_low} <= b;
		addr <= a;
		dqm <= m;
		dq_d <= d;
		@(posedge hclk);
	endtask

	// Idle edges; released data lines toggle so stale words never look valid
	task automatic idle(input int n, input logic m);
		repeat (n)
			cmd(3'h7, 2'h0, 12'h000, m, ~dq_d);
	endtask

	task automatic act(input logic [1:0] b, input logic [11:0] row);
		cmd(3'h3, b, row, 1'b0, ~dq_d);
		idle(ACT_GAP, 1'b0);
	endtask

	task automatic prep(input logic [1:0] b);
		cmd(3'h1, b, {4'h0, PROG_CODE}, 1'b0, ~dq_d);
		act(b, 12'h000);
	endtask

	task automatic wr(input logic [1:0] b, input logic [7:0] col, input logic [127:0] w,
		input logic [7:0] m, input int n);
		cmd(3'h4, b, {4'h0, col}, m[0], w[15:0]);
		for (int i = 1; i < n; i++)
			cmd(3'h7, 2'h0, 12'h000, m[i], w[16*i+:16]);
	endtask
endmodule

// ==== tb/test_sfb_port.sv ====
// Self-checking bench of the burst command port: pin bursts and AHB-Lite registers.
// Assumes the controller model drives the pins and hready loops back from hreadyout.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("Error at %0t: got %h expected %h", $time, g, e); end end
module test_sfb_port;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, dq_oe_n, cmd_exec_stb;
	logic cs_n, ras_n, cas_n, we_n, bank_select_low, bank_select_high, dqm;
	logic [31:0] haddr, hwdata, hrdata, rdat;
	logic [1:0] htrans, read_source;
	logic [2:0] hsize;
	logic [11:0] addr;
	logic [7:0] cmd_exec_code;
	logic [15:0] dq_d, dq_out, w_q[$], e_q[$];
	// Arbitrary identifier word, no meaning
	logic [15:0] ident_word = 16'h1D1D;
	logic [15:0] status_word = 16'h0080;
	// Truncating commands: code, bank, address, edge after read, old words kept
	logic [2:0] tc[6] = '{3'h5, 3'h5, 3'h6, 3'h2, 3'h2, 3'h2};
	logic [1:0] tb[6] = '{2'h1, 2'h1, 2'h0, 2'h2, 2'h0, 2'h1};
	logic [11:0] ta[6] = '{12'h012, 12'h012, 12'h000, 12'h400, 12'h000, 12'h000};
	int tk[6] = '{1, 2, 2, 2, 2, 2};
	int tn[6] = '{1, 2, 2, 2, 4, 2};
	logic [15:0] dv[4] = '{16'h1111, 16'h2222, 16'h0000, 16'h4444};
	int t_q[$], cyc = 0, bad_count = 0, num_checks = 0, r;
	wire hready = hreadyout;
	// Shared data wire: device wins while it drives
	wire [15:0] dq_in = (dq_oe_n === 1'b0) ? dq_out : dq_d;

	sfb_port #(.DATA_W(16), .COL_W(8)) sfb_port_i
	(
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .addr(addr), .bank_select_low(bank_select_low),
		.bank_select_high(bank_select_high), .dqm(dqm), .dq_in(dq_in), .dq_out(dq_out),
		.dq_oe_n(dq_oe_n), .read_source(read_source), .ident_word(ident_word),
		.status_word(status_word), .cmd_exec_code(cmd_exec_code), .cmd_exec_stb(cmd_exec_stb)
	);

	sfb_ctrl_model sfb_ctrl_model_i
	(
		.hclk(hclk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr),
		.bank_select_low(bank_select_low), .bank_select_high(bank_select_high),
		.dqm(dqm), .dq_d(dq_d)
	);

	// 25 MHz clock
	initial
	begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end

	// Edge count and capture of every driven read word
	always @(posedge hclk)
	begin
		cyc <= cyc + 1;
		if (dq_oe_n === 1'b0)
		begin
			w_q.push_back(dq_out);
			t_q.push_back(cyc);
		end
	end

	task automatic report_and_stop();
		$display("Checks %0d, errors %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Bounded wait for hready sampled high
	task automatic wait_ready();
		int n;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (hready !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			bad_count++;
			report_and_stop();
		end
	endtask

	// One single AHB-Lite word transfer; read data lands in rdat
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		wait_ready();
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		rdat = hrdata;
	endtask

	task automatic rreg(input logic [7:0] a, input logic [31:0] e);
		ahb(1'b0, a, 32'h0);
		`CHK(rdat, e)
	endtask

	// Read command; r keeps its edge index
	task automatic rdc(input logic [1:0] b, input logic [7:0] col);
		w_q.delete();
		t_q.delete();
		sfb_ctrl_model_i.cmd(3'h5, b, {4'h0, col}, 1'b0, 16'h0000);
		r = cyc;
	endtask

	// Captured words must equal e_q, back to back from edge r + l
	task automatic chk_burst(input int l);
		`CHK(w_q.size(), e_q.size())
		foreach (e_q[i])
		begin
			`CHK(w_q[i], e_q[i])
			`CHK(t_q[i], r + l + i)
		end
		e_q.delete();
	endtask

	task automatic rd(input logic [1:0] b, input logic [7:0] col);
		rdc(b, col);
		sfb_ctrl_model_i.idle(10, 1'b0);
		chk_burst(2);
	endtask

	// Main sequence
	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		read_source = 2'h0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rreg(8'h00, 32'h02);
		ahb(1'b1, 8'h04, 32'hFF);
		rreg(8'h04, 32'h00);
		rreg(8'h40, 32'h00);
		`CHK(hresp, 1'b0)
		ahb(1'b1, 8'h00, 32'h0A);
		rreg(8'h00, 32'h0A);
		sfb_ctrl_model_i.cmd(3'h1, 2'h1, 12'h05A, 1'b0, 16'h0000);
		#1;
		`CHK(cmd_exec_stb, 1'b1)
		`CHK(cmd_exec_code, 8'h5A)
		sfb_ctrl_model_i.act(2'h1, 12'h123);
		`CHK(cmd_exec_stb, 1'b0)
		rreg(8'h04, 32'h10);
		rreg(8'h08, 32'h5A);
		// Third word masked, two surplus words after the burst
		sfb_ctrl_model_i.wr(2'h1, 8'h10, 128'h6666_5555_4444_3333_2222_1111, 8'h04, 6);
		sfb_ctrl_model_i.act(2'h1, 12'h123);
		rreg(8'h04, 32'h02);
		rreg(8'h14, 32'h123);
		sfb_ctrl_model_i.prep(2'h1);
		sfb_ctrl_model_i.wr(2'h1, 8'h20, 128'h7777, 8'h01, 1);
		sfb_ctrl_model_i.act(2'h1, 12'h123);
		for (int l = 1; l < 4; l++)
		begin
			ahb(1'b1, 8'h00, 32'h08 | l);
			rdc(2'h1, 8'h10);
			sfb_ctrl_model_i.idle(10, 1'b0);
			foreach (dv[j])
				e_q.push_back(dv[j]);
			chk_burst(l);
		end
		ahb(1'b1, 8'h00, 32'h0A);
		e_q = '{16'h0, 16'h4444, 16'h0, 16'h0};
		rd(2'h1, 8'h12);
		e_q = '{16'h0, 16'h0, 16'h0, 16'h0};
		rd(2'h1, 8'h20);
		e_q = '{16'h0, 16'h0, 16'h0, 16'h0};
		sfb_ctrl_model_i.act(2'h0, 12'h000);
		rd(2'h0, 8'h10);
		for (int i = 0; i < 6; i++)
		begin
			rdc(2'h1, 8'h10);
			sfb_ctrl_model_i.idle(tk[i] - 1, 1'b0);
			sfb_ctrl_model_i.cmd(tc[i], tb[i], ta[i], 1'b0, 16'h0000);
			sfb_ctrl_model_i.idle(10, 1'b0);
			for (int j = 0; j < tn[i]; j++)
				e_q.push_back(dv[j]);
			if (tc[i] == 3'h5)
				e_q = {e_q, 16'h0, 16'h4444, 16'h0, 16'h0};
			chk_burst(2);
			sfb_ctrl_model_i.act(2'h1, 12'h123);
		end
		// Mode load with bank 1 open must leave rows and config alone
		sfb_ctrl_model_i.cmd(3'h0, 2'h0, 12'h3FF, 1'b0, 16'h0000);
		rreg(8'h04, 32'h02);
		rreg(8'h00, 32'h0A);
		rdc(2'h1, 8'h10);
		sfb_ctrl_model_i.idle(1, 1'b1);
		sfb_ctrl_model_i.idle(10, 1'b0);
		`CHK(w_q.size(), 3)
		`CHK(t_q[1], r + 4)
		// Mask up two edges ahead, write on the third
		rdc(2'h1, 8'h10);
		sfb_ctrl_model_i.idle(2, 1'b1);
		sfb_ctrl_model_i.wr(2'h1, 8'h30, 128'hA4A4_A3A3_A2A2_A1A1, 8'h00, 4);
		sfb_ctrl_model_i.idle(6, 1'b0);
		e_q = '{16'h1111};
		chk_burst(2);
		e_q = '{16'hA1A1, 16'hA2A2, 16'hA3A3, 16'hA4A4};
		rd(2'h1, 8'h30);
		ahb(1'b1, 8'h00, 32'h0E);
		sfb_ctrl_model_i.prep(2'h2);
		sfb_ctrl_model_i.wr(2'h2, 8'hFC, 128'hE7E7E6E6E5E5E4E4E3E3E2E2E1E1E0E0, 8'h00, 8);
		sfb_ctrl_model_i.act(2'h2, 12'h055);
		ahb(1'b1, 8'h00, 32'h1E);
		rdc(2'h2, 8'hFC);
		sfb_ctrl_model_i.idle(7, 1'b0);
		sfb_ctrl_model_i.cmd(3'h6, 2'h0, 12'h000, 1'b0, 16'h0000);
		sfb_ctrl_model_i.idle(10, 1'b0);
		for (int j = 0; j < 8; j++)
			e_q.push_back({2{4'hE, 4'(j)}});
		chk_burst(2);
		ahb(1'b1, 8'h00, 32'h2A);
		sfb_ctrl_model_i.prep(2'h3);
		sfb_ctrl_model_i.wr(2'h3, 8'h00, 128'hF3F3_F2F2_F1F1_F0F0, 8'h00, 4);
		sfb_ctrl_model_i.act(2'h3, 12'h001);
		e_q = '{16'hF0F0, 16'h0, 16'h0, 16'h0};
		rd(2'h3, 8'h00);
		for (int s = 1; s < 3; s++)
		begin
			read_source <= 2'(s);
			repeat (4)
				e_q.push_back((s == 1) ? ident_word : status_word);
			rd(2'h1, 8'h10);
		end
		report_and_stop();
	end
endmodule
